// ---- stc_consts.svh ----
// constants for the statistics counter bank
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH
`define STC_ADR_W       20
`define STC_MAX_COUNT   31'h4000_0000
`define STC_PTR_LO      7'h5d
`define STC_PTR_HI      7'h7f
`define STC_SHARED_LINE 3'h7
`define STC_SHARED_VC   5'h1f
`define STC_VC_ZERO     5'h00
`define STC_CNT_SHARED  4'h0
`define STC_CNT_UNUSED  4'h1
`define STC_CNT_REJPTR  4'ha
`define STC_CNT_MULTI   4'hb
`define STC_CNT_STARV   4'hd
`define STC_ATM_LAST    4'h5
`define STC_BANK_CNT    1'h0
`define STC_BANK_THR    1'h1
`define STC_RAM_PAD     3'h0
`define STC_BANK_TAG    4'h8
`define STC_REG_ATM_EN  20'h00000
`define STC_REG_AAL_EN  20'h00004
`define STC_REG_CTRL    20'h00008
`define STC_REG_STAT    20'h0000c
`define STC_CTRL_UF     0
`define STC_CTRL_ONCE   1
`define STC_FLAG_BIT    31
`define STC_BE_ALL      4'hf
`endif

// ---- stc_pkg.sv ----
// types shared by the statistics counter bank
package stc_pkg;
  typedef enum logic [2:0] {
    STC_IDLE = 3'h0,
    STC_CRD  = 3'h1,
    STC_TRD  = 3'h3,
    STC_CAP  = 3'h2,
    STC_WR   = 3'h6,
    STC_WBA  = 3'h4,
    STC_WBD  = 3'h5
  } stc_state_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] line_index;
    logic [4:0] vc_index;
    logic       is_aal;
    logic       unstructured;
    logic       chan_active;
    logic [3:0] counter_index;
    logic [6:0] ptr_value;
    logic       ptr_par_err;
  } stc_ev_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] line_index;
    logic [4:0] vc_index;
    logic [3:0] counter_index;
  } stc_iq_t;

  typedef struct packed {
    stc_state_t  st;
    logic        ack;
    logic [31:0] dat;
    logic [15:0] ram_adr;
    logic        ram_en;
    logic        ram_we;
    logic [3:0]  ram_be;
    logic [31:0] ram_wd;
    logic        pend;
    logic        rdy;
    logic [11:0] tgt;
    logic [31:0] cword;
    stc_iq_t     iq;
    logic [15:0] atm_en;
    logic [15:0] aal_en;
    logic [1:0]  ctrl;
  } stc_regs_t;
endpackage

// ---- stc_map.sv ----
// maps a raw event onto a counter word index, or drops it
`include "stc_consts.svh"
module stc_map (
  input  wire stc_pkg::stc_ev_t ev_i,
  input  wire logic [15:0]      atm_en_i,
  input  wire logic [15:0]      aal_en_i,
  input  wire logic [1:0]       ctrl_i,
  output logic                  hit_o,
  output logic [11:0]           idx_o
);
  logic [2:0] line;
  logic [4:0] vc;
  logic [3:0] cnt;
  logic       ok;
  logic       bad_ptr;

  always_comb begin
    line    = ev_i.line_index;
    vc      = ev_i.vc_index;
    cnt     = ev_i.counter_index;
    ok      = ev_i.valid && ev_i.chan_active;
    bad_ptr = (ev_i.ptr_value > `STC_PTR_LO) && (ev_i.ptr_value < `STC_PTR_HI);
    if (!ev_i.is_aal) begin
      vc = `STC_VC_ZERO;
      ok = ok && (cnt <= `STC_ATM_LAST) && atm_en_i[cnt];
    end else begin
      ok = ok && aal_en_i[cnt] && (cnt != `STC_CNT_UNUSED);
      if (ev_i.unstructured) begin
        vc = `STC_VC_ZERO;
      end
      if (cnt == `STC_CNT_SHARED) begin
        line = `STC_SHARED_LINE;
        vc   = `STC_SHARED_VC;
      end
      // no starvation cells go out while the buffer restarts itself
      if (cnt == `STC_CNT_STARV && ctrl_i[`STC_CTRL_UF]) begin
        ok = 1'b0;
      end
      if (cnt == `STC_CNT_REJPTR && !ev_i.ptr_par_err && !bad_ptr) begin
        ok = 1'b0;
      end
      if (cnt == `STC_CNT_MULTI && !ctrl_i[`STC_CTRL_ONCE]) begin
        ok = 1'b0;
      end
    end
    hit_o = ok;
    idx_o = {line, vc, cnt};
  end
endmodule

// ---- stc_sat.sv ----
// saturating increment and threshold check of one counter word
`include "stc_consts.svh"
module stc_sat (
  input  wire logic [31:0] cword_i,
  input  wire logic [31:0] thr_i,
  output logic [31:0]      nword_o,
  output logic             fire_o
);
  logic [30:0] n;

  always_comb begin
    n = cword_i[30:0];
    if (n < `STC_MAX_COUNT) begin
      n = 31'(n + 31'h1);
    end
    // thresholds above the ceiling can never be met, as intended
    fire_o  = thr_i[`STC_FLAG_BIT] && !cword_i[`STC_FLAG_BIT]
              && (n >= thr_i[30:0]);
    nword_o = {cword_i[`STC_FLAG_BIT] | fire_o, n};
  end
endmodule

// ---- stc_top.sv ----
// statistics counter bank: wishbone slave, event mapper, ram updates
// Function
// - atm port counters sit at channel zero
// - atm ports count six cell error events
// - aal counter 0 shared at line7, channel31
// - unstructured aal counters other than 0 sit at channel zero
// - counter 2 counts cells written to buffer
// - counter 3 counts misaligned multiframe pulses
// - counter 4 counts cells over fill threshold
// - counter 5 counts end of overflow episodes
// - counter 6 counts all aal1 header errors
// - counter 7 counts sequence sync losses
// - counter 8 counts misinserted cells
// - counter 9 counts sequence algorithm discards
// - counter 10 counts rejected structure pointers
// - counter 11 counts extra pointers when single
// - counters 12, 13 count underflow starts, starvation
// - counter 14 counts pointer reacquisitions
// - counter 15 counts lost cells
// - self restart on underflow freezes counter 13
// - word holds 31-bit count plus entry flag
// - at most one queue entry per counter
// - counter saturates at its maximum
// - threshold bank mirrors counter bank shape
// - count only when channel active and enabled
// - reaching threshold writes a queue entry
`include "stc_consts.svh"
module stc_top (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   cyc_i,
  input  wire logic                   stb_i,
  input  wire logic                   we_i,
  input  wire logic [`STC_ADR_W-1:0]  adr_i,
  input  wire logic [3:0]             sel_i,
  input  wire logic [31:0]            dat_i,
  output logic [31:0]                 dat_o,
  output logic                        ack_o,
  input  wire stc_pkg::stc_ev_t       ev_i,
  output logic                        ev_ready_o,
  output logic [15:0]                 ext_ram_address_o,
  output logic                        ram_en_o,
  output logic                        ram_we_o,
  output logic [3:0]                  ram_be_o,
  output logic [31:0]                 ram_wdata_o,
  input  wire logic [31:0]            ram_rdata_i,
  output stc_pkg::stc_iq_t            iq_o
);
  stc_pkg::stc_regs_t r;
  stc_pkg::stc_regs_t next_r;
  logic               map_hit;
  logic [11:0]        map_idx;
  logic [31:0]        sat_word;
  logic               sat_fire;
  logic               req;
  logic               bank_hit;

  stc_map u_map (
    .ev_i     (ev_i),
    .atm_en_i (r.atm_en),
    .aal_en_i (r.aal_en),
    .ctrl_i   (r.ctrl),
    .hit_o    (map_hit),
    .idx_o    (map_idx)
  );

  stc_sat u_sat (
    .cword_i  (r.cword),
    .thr_i    (ram_rdata_i),
    .nword_o  (sat_word),
    .fire_o   (sat_fire)
  );

  assign req      = cyc_i && stb_i && !r.ack;
  assign bank_hit = adr_i[`STC_ADR_W-1:15] == {1'b0, `STC_BANK_TAG};

  always_comb begin
    next_r          = r;
    next_r.ack      = 1'b0;
    next_r.ram_en   = 1'b0;
    next_r.ram_we   = 1'b0;
    next_r.iq.valid = 1'b0;
    // the event class is the counter number, carried by counter_index;
    // unmatched or disabled events are consumed and lost
    if (ev_i.valid && r.rdy && map_hit) begin
      next_r.pend = 1'b1;
      next_r.tgt  = map_idx;
    end
    case (r.st)
      stc_pkg::STC_IDLE: begin
        if (req && bank_hit) begin
          // software reaches either bank through the same window
          next_r.st      = stc_pkg::STC_WBA;
          next_r.ram_adr = {`STC_RAM_PAD, adr_i[14:2]};
          next_r.ram_en  = 1'b1;
          next_r.ram_we  = we_i;
          next_r.ram_be  = sel_i;
          next_r.ram_wd  = dat_i;
        end else if (req) begin
          next_r.ack = 1'b1;
          next_r.dat = 32'h0;
          case (adr_i)
            `STC_REG_ATM_EN: begin
              if (we_i) begin
                next_r.atm_en = dat_i[15:0];
              end else begin
                next_r.dat = {16'h0, r.atm_en};
              end
            end
            `STC_REG_AAL_EN: begin
              if (we_i) begin
                next_r.aal_en = dat_i[15:0];
              end else begin
                next_r.dat = {16'h0, r.aal_en};
              end
            end
            `STC_REG_CTRL: begin
              if (we_i) begin
                next_r.ctrl = dat_i[1:0];
              end else begin
                next_r.dat = {30'h0, r.ctrl};
              end
            end
            `STC_REG_STAT: begin
              next_r.dat = {16'h0, 3'h0, r.pend, r.tgt};
            end
            default: begin
              next_r.dat = 32'h0;
            end
          endcase
        end else if (r.pend) begin
          // bus accesses win; an update never starts mid-access
          next_r.st      = stc_pkg::STC_CRD;
          next_r.ram_adr = {`STC_RAM_PAD, `STC_BANK_CNT, r.tgt};
          next_r.ram_en  = 1'b1;
        end
      end
      stc_pkg::STC_CRD: begin
        next_r.st      = stc_pkg::STC_TRD;
        next_r.ram_adr = {`STC_RAM_PAD, `STC_BANK_THR, r.tgt};
        next_r.ram_en  = 1'b1;
      end
      stc_pkg::STC_TRD: begin
        next_r.st    = stc_pkg::STC_CAP;
        next_r.cword = ram_rdata_i;
      end
      stc_pkg::STC_CAP: begin
        next_r.st       = stc_pkg::STC_WR;
        next_r.ram_adr  = {`STC_RAM_PAD, `STC_BANK_CNT, r.tgt};
        next_r.ram_en   = 1'b1;
        next_r.ram_we   = 1'b1;
        next_r.ram_be   = `STC_BE_ALL;
        next_r.ram_wd   = sat_word;
        next_r.iq.valid = sat_fire;
        next_r.iq.line_index    = r.tgt[11:9];
        next_r.iq.vc_index      = r.tgt[8:4];
        next_r.iq.counter_index = r.tgt[3:0];
      end
      stc_pkg::STC_WR: begin
        next_r.st   = stc_pkg::STC_IDLE;
        next_r.pend = 1'b0;
      end
      stc_pkg::STC_WBA: begin
        next_r.st = stc_pkg::STC_WBD;
      end
      stc_pkg::STC_WBD: begin
        next_r.st  = stc_pkg::STC_IDLE;
        next_r.ack = 1'b1;
        next_r.dat = we_i ? 32'h0 : ram_rdata_i;
      end
      default: begin
        next_r.st = stc_pkg::STC_IDLE;
      end
    endcase
    // one event is held at a time; the source waits on ready
    next_r.rdy = !next_r.pend;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r        <= '0;
      r.st     <= stc_pkg::STC_IDLE;
      r.rdy    <= 1'b1;
      r.ram_be <= `STC_BE_ALL;
    end else begin
      r <= next_r;
    end
  end

  assign dat_o             = r.dat;
  assign ack_o             = r.ack;
  assign ev_ready_o        = r.rdy;
  assign ext_ram_address_o = r.ram_adr;
  assign ram_en_o          = r.ram_en;
  assign ram_we_o          = r.ram_we;
  assign ram_be_o          = r.ram_be;
  assign ram_wdata_o       = r.ram_wd;
  assign iq_o              = r.iq;

  shared_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ev_i.valid && r.rdy && map_hit && ev_i.is_aal
    && ev_i.counter_index == `STC_CNT_SHARED
    |=> r.tgt == {`STC_SHARED_LINE, `STC_SHARED_VC, `STC_CNT_SHARED})
    else $error("shared counter not at line 7 channel 31");

  atm_vc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ev_i.valid && r.rdy && map_hit && !ev_i.is_aal |=> r.tgt[8:4] == `STC_VC_ZERO)
    else $error("atm counter outside channel zero");

  starv_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ev_i.valid && ev_i.is_aal && ev_i.counter_index == `STC_CNT_STARV
    && r.ctrl[`STC_CTRL_UF] |-> !map_hit)
    else $error("starvation counted during self restart");

  ptr_reject_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ev_i.valid && ev_i.is_aal && ev_i.counter_index == `STC_CNT_REJPTR
    && !ev_i.ptr_par_err && (ev_i.ptr_value <= `STC_PTR_LO
    || ev_i.ptr_value >= `STC_PTR_HI) |-> !map_hit)
    else $error("valid pointer counted as rejected");

  enable_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ev_i.valid && !ev_i.chan_active |-> !map_hit)
    else $error("event counted on inactive channel");

  rmw_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
    r.st == stc_pkg::STC_CRD |=> r.st == stc_pkg::STC_TRD ##1 r.st == stc_pkg::STC_CAP
    ##1 r.st == stc_pkg::STC_WR && r.ram_we ##1 r.st == stc_pkg::STC_IDLE)
    else $error("update sequence broken");

  sat_limit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    r.st == stc_pkg::STC_WR && r.cword[30:0] <= `STC_MAX_COUNT
    |-> r.ram_wd[30:0] <= `STC_MAX_COUNT
    && r.ram_wd[30:0] >= r.cword[30:0])
    else $error("counter passed its ceiling");

  single_iq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    r.iq.valid |-> r.st == stc_pkg::STC_WR && !r.cword[`STC_FLAG_BIT]
    && r.ram_wd[`STC_FLAG_BIT] && r.iq.counter_index == r.tgt[3:0])
    else $error("queue entry repeated or unflagged");

  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    r.ack |=> !r.ack)
    else $error("ack held two cycles");

  cover_update_c: cover property (@(posedge clk_i) disable iff (rst_i)
    r.st == stc_pkg::STC_WR);
  cover_iq_c: cover property (@(posedge clk_i) disable iff (rst_i)
    r.iq.valid);
  cover_bank_rd_c: cover property (@(posedge clk_i) disable iff (rst_i)
    r.st == stc_pkg::STC_WBD && !we_i);
  cover_stall_c: cover property (@(posedge clk_i) disable iff (rst_i)
    ev_i.valid && !r.rdy);
endmodule

// ---- stc_tb.sv ----
// self-checking bench for the statistics counter bank
`include "stc_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              cyc_i = 1'b0;
  logic              stb_i = 1'b0;
  logic              we_i = 1'b0;
  logic [19:0]       adr_i = 20'h00000;
  logic [3:0]        sel_i = 4'hf;
  logic [31:0]       dat_i = 32'h0;
  logic [31:0]       dat_o;
  logic              ack_o;
  stc_pkg::stc_ev_t  ev_i = '0;
  logic              ev_ready_o;
  logic [15:0]       ext_ram_address_o;
  logic              ram_en_o;
  logic              ram_we_o;
  logic [3:0]        ram_be_o;
  logic [31:0]       ram_wdata_o;
  logic [31:0]       ram_rdata_i = 32'h0;
  stc_pkg::stc_iq_t  iq_o;
  stc_pkg::stc_iq_t  iq_last = '0;
  logic [31:0]       mem [0:65535];
  logic [31:0]       rd;
  int                err_count = 0;
  int                comparisons = 0;
  int                iq_cnt = 0;

  stc_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ev_i(ev_i),
    .ev_ready_o(ev_ready_o), .ext_ram_address_o(ext_ram_address_o), .ram_en_o(ram_en_o),
    .ram_we_o(ram_we_o), .ram_be_o(ram_be_o), .ram_wdata_o(ram_wdata_o),
    .ram_rdata_i(ram_rdata_i), .iq_o(iq_o));

  always #4 clk_i = ~clk_i;

  // synchronous ram; read data scrambles when not selected so a stale word is never trusted
  always @(posedge clk_i) begin
    if (ram_en_o === 1'b1) begin
      ram_rdata_i <= mem[ext_ram_address_o];
      if (ram_we_o === 1'b1)
        for (int b = 0; b < 4; b++)
          if (ram_be_o[b]) mem[ext_ram_address_o][8*b+:8] <= ram_wdata_o[8*b+:8];
    end else
      ram_rdata_i <= ~ram_rdata_i;
    if (iq_o.valid === 1'b1) begin
      iq_cnt <= iq_cnt + 1;
      iq_last <= iq_o;
    end
  end

  function automatic logic [15:0] ix(input logic b, input logic [2:0] l,
                                     input logic [4:0] v, input logic [3:0] c);
    return {3'h0, b, l, v, c};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [19:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    if (n >= 50) err_count++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  // preload one word, offer one event, then wait for the update to land
  task automatic ev(input logic [15:0] ri, input logic [31:0] pre, input logic [2:0] l,
                    input logic [4:0] v, input logic aal, input logic un, input logic act,
                    input logic [3:0] c, input logic [6:0] p, input logic pe);
    int n;
    n = 0;
    mem[ri] = pre;
    @(posedge clk_i);
    ev_i <= {1'b1, l, v, aal, un, act, c, p, pe};
    do begin
      @(posedge clk_i);
      n++;
    end while (ev_ready_o !== 1'b1 && n < 50);
    ev_i.valid <= 1'b0;
    repeat (2) @(posedge clk_i);
    while (ev_ready_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    repeat (2) @(posedge clk_i);
    if (n >= 50) err_count++;
  endtask

  task automatic t_regs();
    wb(1'b0, `STC_REG_ATM_EN, 32'h0, rd);
    chk("atm enable after reset", rd, 32'h0);
    wb(1'b1, `STC_REG_ATM_EN, 32'h0000003f, rd);
    wb(1'b1, `STC_REG_AAL_EN, 32'h0000fffd, rd);
    wb(1'b1, `STC_REG_CTRL, 32'h00000002, rd);
    wb(1'b0, `STC_REG_AAL_EN, 32'h0, rd);
    chk("aal enable", rd, 32'h0000fffd);
    wb(1'b0, 20'h00020, 32'h0, rd);
    chk("unmapped read", rd, 32'h0);
    wb(1'b0, `STC_REG_STAT, 32'h0, rd);
    chk("status idle", rd, 32'h0);
  endtask

  task automatic t_bank();
    wb(1'b1, 20'h40000 | 20'({ix(1'b0, 3'h2, 5'h09, 4'h6), 2'b00}), 32'h00001234, rd);
    chk("bank write", mem[ix(1'b0, 3'h2, 5'h09, 4'h6)], 32'h00001234);
    mem[ix(1'b1, 3'h4, 5'h03, 4'hf)] = 32'h800000aa;
    wb(1'b0, 20'h40000 | 20'({ix(1'b1, 3'h4, 5'h03, 4'hf), 2'b00}), 32'h0, rd);
    chk("threshold read", rd, 32'h800000aa);
  endtask

  task automatic t_classes();
    logic [15:0] a;
    for (int i = 2; i < 16; i++) begin
      a = ix(1'b0, 3'h3, 5'h05, 4'(i));
      ev(a, 32'(i), 3'h3, 5'h05, 1'b1, 1'b0, 1'b1, 4'(i), 7'h00, 1'b1);
      chk("aal counter", mem[a], 32'(i + 1));
    end
    for (int i = 0; i < 6; i++) begin
      ev(ix(1'b0, 3'h1, 5'h00, 4'(i)), 32'h9, 3'h1, 5'h07, 1'b0, 1'b0, 1'b1, 4'(i), 7'h00, 1'b0);
      chk("atm counter", mem[ix(1'b0, 3'h1, 5'h00, 4'(i))], 32'ha);
    end
    chk("atm own channel", mem[ix(1'b0, 3'h1, 5'h07, 4'h0)], 32'h0);
    ev(ix(1'b0, 3'h7, 5'h1f, 4'h0), 32'h5, 3'h1, 5'h04, 1'b1, 1'b0, 1'b1, 4'h0, 7'h00, 1'b0);
    chk("shared counter", mem[ix(1'b0, 3'h7, 5'h1f, 4'h0)], 32'h6);
    ev(ix(1'b0, 3'h5, 5'h00, 4'hc), 32'h0, 3'h5, 5'h09, 1'b1, 1'b1, 1'b1, 4'hc, 7'h00, 1'b0);
    chk("unstructured", mem[ix(1'b0, 3'h5, 5'h00, 4'hc)], 32'h1);
  endtask

  task automatic t_filter();
    logic [6:0] pv [4] = '{7'h5d, 7'h5e, 7'h7e, 7'h7f};
    logic [15:0] r;
    wb(1'b1, `STC_REG_ATM_EN, 32'h0000ffff, rd);
    wb(1'b1, `STC_REG_AAL_EN, 32'h0000ffff, rd);
    r = ix(1'b0, 3'h1, 5'h00, 4'h6);
    ev(r, 32'h9, 3'h1, 5'h00, 1'b0, 1'b0, 1'b1, 4'h6, 7'h00, 1'b0);
    chk("atm index above five", mem[r], 32'h9);
    r = ix(1'b0, 3'h2, 5'h03, 4'h1);
    ev(r, 32'h9, 3'h2, 5'h03, 1'b1, 1'b0, 1'b1, 4'h1, 7'h00, 1'b0);
    chk("aal counter one unused", mem[r], 32'h9);
    wb(1'b1, `STC_REG_ATM_EN, 32'h0000003f, rd);
    wb(1'b1, `STC_REG_AAL_EN, 32'h0000fffd, rd);
    r = ix(1'b0, 3'h2, 5'h03, 4'ha);
    for (int i = 0; i < 4; i++) begin
      ev(r, 32'h10, 3'h2, 5'h03, 1'b1, 1'b0, 1'b1, 4'ha, pv[i], 1'b0);
      chk("pointer reject", mem[r], (i == 1 || i == 2) ? 32'h11 : 32'h10);
    end
    r = ix(1'b0, 3'h2, 5'h03, 4'h2);
    ev(r, 32'h3, 3'h2, 5'h03, 1'b1, 1'b0, 1'b0, 4'h2, 7'h00, 1'b0);
    chk("inactive channel", mem[r], 32'h3);
    wb(1'b1, `STC_REG_AAL_EN, 32'h0000fff9, rd);
    ev(r, 32'h3, 3'h2, 5'h03, 1'b1, 1'b0, 1'b1, 4'h2, 7'h00, 1'b0);
    chk("disabled counter", mem[r], 32'h3);
    wb(1'b1, `STC_REG_AAL_EN, 32'h0000fffd, rd);
    wb(1'b1, `STC_REG_CTRL, 32'h00000001, rd);
    r = ix(1'b0, 3'h2, 5'h03, 4'hd);
    ev(r, 32'h3, 3'h2, 5'h03, 1'b1, 1'b0, 1'b1, 4'hd, 7'h00, 1'b0);
    chk("starvation frozen", mem[r], 32'h3);
    r = ix(1'b0, 3'h2, 5'h03, 4'hb);
    ev(r, 32'h3, 3'h2, 5'h03, 1'b1, 1'b0, 1'b1, 4'hb, 7'h00, 1'b0);
    chk("multi pointer off", mem[r], 32'h3);
    wb(1'b1, `STC_REG_CTRL, 32'h00000002, rd);
  endtask

  task automatic t_sat();
    logic [15:0] r;
    r = ix(1'b0, 3'h0, 5'h0b, 4'h9);
    ev(r, 32'h40000000, 3'h0, 5'h0b, 1'b1, 1'b0, 1'b1, 4'h9, 7'h00, 1'b0);
    chk("saturated", mem[r], 32'h40000000);
    ev(r, 32'h3fffffff, 3'h0, 5'h0b, 1'b1, 1'b0, 1'b1, 4'h9, 7'h00, 1'b0);
    chk("reach maximum", mem[r], 32'h40000000);
  endtask

  task automatic t_thr();
    int n0;
    logic [15:0] r;
    n0 = iq_cnt;
    r = ix(1'b0, 3'h6, 5'h11, 4'h9);
    mem[ix(1'b1, 3'h6, 5'h11, 4'h9)] = 32'h80000002;
    ev(r, 32'h1, 3'h6, 5'h11, 1'b1, 1'b0, 1'b1, 4'h9, 7'h00, 1'b0);
    chk("flagged word", mem[r], 32'h80000002);
    chk("queue entries", 32'(iq_cnt - n0), 32'h1);
    chk("queue entry", 32'({iq_last.line_index, iq_last.vc_index, iq_last.counter_index}),
        32'({3'h6, 5'h11, 4'h9}));
    ev(r, 32'h80000002, 3'h6, 5'h11, 1'b1, 1'b0, 1'b1, 4'h9, 7'h00, 1'b0);
    chk("flag kept", mem[r], 32'h80000003);
    chk("single entry", 32'(iq_cnt - n0), 32'h1);
  endtask

  initial begin
    foreach (mem[i]) mem[i] = 32'h0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_bank();
    t_classes();
    t_filter();
    t_sat();
    t_thr();
    end_sim();
  end

  // the whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    end_sim();
  end
endmodule
